/* File: verilog/cpdm_pkg.sv */
// package for the configuration register slice (indices 07h..0Bh)
package cpdm_pkg;
   // register indices as seen in the configuration index register
   localparam logic [7:0] IDX_POWER_BOOT = 8'h07;
   localparam logic [7:0] IDX_DEC_LOW = 8'h08;
   localparam logic [7:0] IDX_DEC_HIGH = 8'h09;
   localparam logic [7:0] IDX_THR_IR = 8'h0A;
   localparam logic [7:0] IDX_RATE = 8'h0B;
   // reset values
   localparam logic [7:0] RST_POWER_BOOT = 8'h00;
   localparam logic [7:0] RST_DEC_LOW = 8'h00;
   localparam logic [7:0] RST_DEC_HIGH = 8'h00;
   localparam logic [7:0] RST_THR_IR = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h00;
   // writable bit masks; zero bits are reserved and read as zero
   localparam logic [7:0] MASK_POWER_BOOT = 8'hF3;
   localparam logic [7:0] MASK_DEC_LOW = 8'hF0;
   localparam logic [7:0] MASK_DEC_HIGH = 8'hC7;
   localparam logic [7:0] MASK_THR_IR = 8'hCF;
   localparam logic [7:0] MASK_RATE = 8'hFF;
   // field positions
   localparam int POS_BOOT = 0;
   localparam int POS_APD_PAR = 4;
   localparam int POS_APD_SER2 = 5;
   localparam int POS_APD_SER1 = 6;
   localparam int POS_APD_FLOPPY = 7;
   localparam int POS_MODE_LO = 6;
   localparam int POS_ROUTE_LO = 6;
   // decoder modes
   localparam logic [1:0] DEC_OFF = 2'h0;
   localparam logic [1:0] DEC_BYTE1 = 2'h1;
   localparam logic [1:0] DEC_BLOCK8 = 2'h2;
   localparam logic [1:0] DEC_BLOCK16 = 2'h3;
   // infrared routes
   localparam logic [1:0] IR_PRIMARY = 2'h0;
   localparam logic [1:0] IR_SECONDARY = 2'h1;
   localparam logic [1:0] IR_RESERVED = 2'h2;
   localparam logic [1:0] IR_OFF = 2'h3;

   // host configuration-port access
   typedef struct packed {
      logic cfg_state;
      logic [7:0] index;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cpdm_cfg_req_type;

   // infrared pin group toward the pads
   typedef struct packed {
      logic tx_primary;
      logic tx_primary_oe_n;
      logic tx_secondary;
      logic tx_secondary_oe_n;
      logic rx_active;
   } cpdm_ir_pins_type;
endpackage

/* File: verilog/cpdm_addr_decoder.sv */
// general-purpose address decoder with 1/8/16 byte block modes
`timescale 1ns/1ps
module cpdm_addr_decoder (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic [6:0] match,
   input wire logic [10:0] host_addr,
   input wire logic host_select_n,
   output logic hit_q
);
   logic low_ok;

   // low-nibble qualification per block mode
   always_comb begin
      case (mode)
         cpdm_pkg::DEC_BYTE1: low_ok = (host_addr[3:0] == 4'h0);
         cpdm_pkg::DEC_BLOCK8: low_ok = ~host_addr[3];
         cpdm_pkg::DEC_BLOCK16: low_ok = 1'b1;
         default: low_ok = 1'b0; // disabled
      endcase
   end

   // registered so the top output comes straight from a flop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= low_ok && (host_addr[10:4] == match) && !host_select_n;
      end
   end
endmodule // cpdm_addr_decoder

/* File: verilog/cpdm_regs.sv */
// configuration registers 07h..0Bh: power-down, boot, decoder, threshold, ir mux, rates
`timescale 1ns/1ps

// What this block does
// - registers are read and written only in configuration state with the index at 07h..0Bh.
// - all five registers load 00h at reset.
// - boot select 0 picks drive A and 1 picks drive B.
// - bits 7..4 of the power/boot register enable auto power-down of floppy, serial 1, serial 2, parallel.
// - the auto power-down enables clear on power-on or hardware reset.
// - reserved bits ignore writes and read as zero.
// - low-address bits 7:4 hold the decoder match for host address 7:4.
// - high-address bits 2:0 hold the decoder match for host address 10:8.
// - the decoder mode picks off, single byte, 8-byte or 16-byte blocks.
// - the decoder output needs the host chip select low.
// - threshold bits 3:0 give the ECP FIFO threshold.
// - the infrared route picks primary, secondary, reserved, or both transmitters off.
// - the infrared route clears on power-on or hardware reset.
// - the rate register holds a 2-bit table select per floppy drive.
module cpdm_regs #(
   parameter int DRIVES = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hw_reset,
   input wire cpdm_pkg::cpdm_cfg_req_type cfg_req,
   output logic [7:0] rdata_q,
   output logic rdata_valid_q,
   input wire logic [10:0] host_addr,
   input wire logic host_select_n,
   output logic general_addr_decoder_q,
   output logic boot_drive_b_q,
   output logic apd_parallel_q,
   output logic apd_serial2_q,
   output logic apd_serial1_q,
   output logic apd_floppy_q,
   output logic [3:0] ecp_threshold_q,
   input wire logic ir_device_tx,
   input wire logic ir_receive_primary,
   input wire logic ir_receive_secondary,
   output cpdm_pkg::cpdm_ir_pins_type ir_pins_q,
   output logic [2*DRIVES-1:0] rate_table_sel_q
);
   logic [7:0] power_down_boot_select_q;
   logic [7:0] decoder_low_address_q;
   logic [7:0] decoder_high_address_mode_q;
   logic [7:0] fifo_threshold_ir_route_q;
   logic [7:0] drive_rate_table_select_q;
   logic cfg_wr;
   logic cfg_rd;
   logic [7:0] rd_mux;
   logic [1:0] ir_route;

   // accesses only count while in configuration state
   assign cfg_wr = cfg_req.cfg_state && cfg_req.wr;
   assign cfg_rd = cfg_req.cfg_state && cfg_req.rd;

   // power/boot register; hardware reset also clears it since it acts like a second reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_down_boot_select_q <= cpdm_pkg::RST_POWER_BOOT;
      end else if (hw_reset) begin
         power_down_boot_select_q <= cpdm_pkg::RST_POWER_BOOT;
      end else if (cfg_wr && cfg_req.index == cpdm_pkg::IDX_POWER_BOOT) begin
         power_down_boot_select_q <= cfg_req.wdata & cpdm_pkg::MASK_POWER_BOOT;
      end
   end

   // decoder address registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         decoder_low_address_q <= cpdm_pkg::RST_DEC_LOW;
         decoder_high_address_mode_q <= cpdm_pkg::RST_DEC_HIGH;
      end else if (hw_reset) begin
         decoder_low_address_q <= cpdm_pkg::RST_DEC_LOW;
         decoder_high_address_mode_q <= cpdm_pkg::RST_DEC_HIGH;
      end else if (cfg_wr) begin
         if (cfg_req.index == cpdm_pkg::IDX_DEC_LOW) begin
            decoder_low_address_q <= cfg_req.wdata & cpdm_pkg::MASK_DEC_LOW;
         end
         if (cfg_req.index == cpdm_pkg::IDX_DEC_HIGH) begin
            decoder_high_address_mode_q <= cfg_req.wdata & cpdm_pkg::MASK_DEC_HIGH;
         end
      end
   end

   // threshold / ir route register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fifo_threshold_ir_route_q <= cpdm_pkg::RST_THR_IR;
      end else if (hw_reset) begin
         fifo_threshold_ir_route_q <= cpdm_pkg::RST_THR_IR;
      end else if (cfg_wr && cfg_req.index == cpdm_pkg::IDX_THR_IR) begin
         fifo_threshold_ir_route_q <= cfg_req.wdata & cpdm_pkg::MASK_THR_IR;
      end
   end

   // drive-rate register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drive_rate_table_select_q <= cpdm_pkg::RST_RATE;
      end else if (hw_reset) begin
         drive_rate_table_select_q <= cpdm_pkg::RST_RATE;
      end else if (cfg_wr && cfg_req.index == cpdm_pkg::IDX_RATE) begin
         drive_rate_table_select_q <= cfg_req.wdata & cpdm_pkg::MASK_RATE;
      end
   end

   // read mux; other indices belong to neighbouring banks and read zero here
   always_comb begin
      case (cfg_req.index)
         cpdm_pkg::IDX_POWER_BOOT: rd_mux = power_down_boot_select_q;
         cpdm_pkg::IDX_DEC_LOW: rd_mux = decoder_low_address_q;
         cpdm_pkg::IDX_DEC_HIGH: rd_mux = decoder_high_address_mode_q;
         cpdm_pkg::IDX_THR_IR: rd_mux = fifo_threshold_ir_route_q;
         cpdm_pkg::IDX_RATE: rd_mux = drive_rate_table_select_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // read data answers one cycle after the read strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         rdata_valid_q <= 1'b0;
      end else begin
         rdata_q <= cfg_rd ? rd_mux : 8'h00;
         rdata_valid_q <= cfg_rd && (cfg_req.index >= cpdm_pkg::IDX_POWER_BOOT)
            && (cfg_req.index <= cpdm_pkg::IDX_RATE);
      end
   end

   // field outputs to the functional units
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_drive_b_q <= 1'b0;
         apd_parallel_q <= 1'b0;
         apd_serial2_q <= 1'b0;
         apd_serial1_q <= 1'b0;
         apd_floppy_q <= 1'b0;
         ecp_threshold_q <= 4'h0;
      end else begin
         boot_drive_b_q <= power_down_boot_select_q[cpdm_pkg::POS_BOOT];
         apd_parallel_q <= power_down_boot_select_q[cpdm_pkg::POS_APD_PAR];
         apd_serial2_q <= power_down_boot_select_q[cpdm_pkg::POS_APD_SER2];
         apd_serial1_q <= power_down_boot_select_q[cpdm_pkg::POS_APD_SER1];
         apd_floppy_q <= power_down_boot_select_q[cpdm_pkg::POS_APD_FLOPPY];
         ecp_threshold_q <= fifo_threshold_ir_route_q[3:0];
      end
   end

   // per-drive rate selects, two bits each
   genvar g;
   generate
      for (g = 0; g < DRIVES; g++) begin : g_rate
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               rate_table_sel_q[2*g+1:2*g] <= 2'h0;
            end else begin
               rate_table_sel_q[2*g+1:2*g] <= drive_rate_table_select_q[2*g+1:2*g];
            end
         end
      end
   endgenerate

   assign ir_route = fifo_threshold_ir_route_q[cpdm_pkg::POS_ROUTE_LO+1:cpdm_pkg::POS_ROUTE_LO];

   // ir pin mux; reserved code parks both transmitters idle but driven, a safe choice
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ir_pins_q <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      end else begin
         case (ir_route)
            cpdm_pkg::IR_PRIMARY: begin
               ir_pins_q <= '{ir_device_tx, 1'b0, 1'b0, 1'b1, ir_receive_primary};
            end
            cpdm_pkg::IR_SECONDARY: begin
               ir_pins_q <= '{1'b0, 1'b1, ir_device_tx, 1'b0, ir_receive_secondary};
            end
            cpdm_pkg::IR_OFF: begin
               ir_pins_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0}; // both high impedance
            end
            default: begin
               ir_pins_q <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            end
         endcase
      end
   end

   // general-purpose decoder
   cpdm_addr_decoder u_dec (
      .clock(clock),
      .rst_n(rst_n),
      .mode(decoder_high_address_mode_q[cpdm_pkg::POS_MODE_LO+1:cpdm_pkg::POS_MODE_LO]),
      .match({decoder_high_address_mode_q[2:0], decoder_low_address_q[7:4]}),
      .host_addr(host_addr),
      .host_select_n(host_select_n),
      .hit_q(general_addr_decoder_q)
   );
endmodule // cpdm_regs

/* File: bench/cpdm_regs_properties.sv */
// concurrent checks on the configuration slice ports
`timescale 1ns/1ps
module cpdm_regs_properties #(
   parameter int DRIVES = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hw_reset,
   input wire cpdm_pkg::cpdm_cfg_req_type cfg_req,
   input wire logic [7:0] rdata_q,
   input wire logic rdata_valid_q,
   input wire logic [10:0] host_addr,
   input wire logic host_select_n,
   input wire logic general_addr_decoder_q,
   input wire logic boot_drive_b_q,
   input wire logic apd_parallel_q,
   input wire logic apd_serial2_q,
   input wire logic apd_serial1_q,
   input wire logic apd_floppy_q,
   input wire logic [3:0] ecp_threshold_q,
   input wire logic ir_device_tx,
   input wire logic ir_receive_primary,
   input wire logic ir_receive_secondary,
   input wire cpdm_pkg::cpdm_ir_pins_type ir_pins_q,
   input wire logic [2*DRIVES-1:0] rate_table_sel_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // a request counts only in configuration state inside the bank
   wire logic in_bank = cfg_req.cfg_state && cfg_req.index >= 8'h07 && cfg_req.index <= 8'h0B;
   function automatic logic [7:0] msk(input logic [7:0] i);
      return i == 8'h07 ? 8'hF3 : i == 8'h08 ? 8'hF0 : i == 8'h09 ? 8'hC7 : i == 8'h0A ? 8'hCF : 8'hFF;
   endfunction
   // a write that no reset or later write disturbs before its fields show
   sequence wr_s(logic [7:0] idx);
      in_bank && cfg_req.wr && !hw_reset && cfg_req.index == idx ##1 !hw_reset && !cfg_req.wr;
   endsequence
   rd_valid_a: assert property (in_bank && cfg_req.rd |=> rdata_valid_q) else $error("no answer");
   rd_refuse_a:
      assert property (!(in_bank && cfg_req.rd) |=> !rdata_valid_q && rdata_q == 8'h00)
      else $error("refused read answered");
   rd_resv_a:
      assert property (rdata_valid_q |-> (rdata_q & ~msk($past(cfg_req.index))) == 8'h00)
      else $error("reserved bit set");
   boot_sel_a:
      assert property (wr_s(8'h07) |=> boot_drive_b_q == $past(cfg_req.wdata[0], 2))
      else $error("boot drive wrong");
   apd_bits_a:
      assert property (wr_s(8'h07) |=> {apd_floppy_q, apd_serial1_q, apd_serial2_q,
      apd_parallel_q} == $past(cfg_req.wdata[7:4], 2)) else $error("power-down bits wrong");
   rate_sel_a:
      assert property (wr_s(8'h0B) |=> rate_table_sel_q[7:0] == $past(cfg_req.wdata, 2))
      else $error("rate selects wrong");
   hw_clear_a:
      assert property (hw_reset |-> ##2 !(apd_floppy_q || apd_serial1_q || apd_serial2_q
      || apd_parallel_q) && !ir_pins_q.tx_primary_oe_n && ir_pins_q.tx_secondary_oe_n)
      else $error("hardware reset left state");
   dec_sel_a: assert property (general_addr_decoder_q |-> $past(!host_select_n))
      else $error("decode without select");
   ir_rx_a:
      assert property (!ir_pins_q.tx_primary_oe_n && ir_pins_q.tx_secondary_oe_n
      && $past(!ir_pins_q.tx_primary_oe_n) |-> ir_pins_q.rx_active == $past(ir_receive_primary))
      else $error("primary receive not routed");
endmodule // cpdm_regs_properties

/* File: bench/cpdm_host_model.sv */
// host side model: configuration port cycles and decoder address traffic
`timescale 1ns/1ps
module cpdm_host_model (
   input wire logic clock,
   input wire logic [7:0] rdata_q,
   input wire logic rdata_valid_q,
   output cpdm_pkg::cpdm_cfg_req_type cfg_req,
   output logic [10:0] host_addr,
   output logic host_select_n
);
   initial begin
      cfg_req = '0;
      host_addr = 11'h000;
      host_select_n = 1'b1;
   end
   // entered just after an edge; the strobe stands until the taking edge
   task automatic cfg_wr(input logic cs, input logic [7:0] idx, input logic [7:0] d);
      cfg_req.cfg_state = cs;
      cfg_req.index = idx;
      cfg_req.wdata = d;
      cfg_req.wr = 1'b1;
      @(posedge clock);
      #1 cfg_req.wr = 1'b0;
      cfg_req.wdata = ~d; // released data must not linger
      // one idle edge so back-to-back calls never rewrite the strobe in one step
      @(posedge clock);
      #1;
   endtask
   // answer lands on the taking edge itself, read just after it once it has landed
   task automatic cfg_rd(input logic cs, input logic [7:0] idx, output logic [7:0] d, output logic v);
      cfg_req.cfg_state = cs;
      cfg_req.index = idx;
      cfg_req.rd = 1'b1;
      @(posedge clock);
      #1 d = rdata_q;
      v = rdata_valid_q;
      cfg_req.rd = 1'b0;
      // idle edge between reads, the strobe is never raised and lowered at once
      @(posedge clock);
      #1;
   endtask
   // one address sample; decode result is settled one edge later
   task automatic addr_drv(input logic [10:0] ad, input logic sn);
      host_addr = ad;
      host_select_n = sn;
      @(posedge clock);
      #1;
   endtask
endmodule // cpdm_host_model

/* File: bench/tb_cpdm_regs.sv */
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
module tb_cpdm_regs;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic hw_reset = 1'b0;
   logic ir_device_tx = 1'b1;
   logic ir_receive_primary = 1'b0;
   logic ir_receive_secondary = 1'b0;
   cpdm_pkg::cpdm_cfg_req_type cfg_req;
   cpdm_pkg::cpdm_ir_pins_type ir_pins_q;
   logic [7:0] rdata_q, rd, a, d, rate_table_sel_q;
   logic [7:0] shadow [7:11];
   logic [10:0] host_addr, ad;
   logic [6:0] m;
   logic [3:0] ecp_threshold_q;
   logic rdata_valid_q, v, host_select_n, general_addr_decoder_q, boot_drive_b_q;
   logic apd_parallel_q, apd_serial2_q, apd_serial1_q, apd_floppy_q;
   int seed = 58;
   int err_count = 0;
   int n_checks = 0;
   always #4 clock = ~clock;
   cpdm_regs #(.DRIVES(4)) u_dut (.*);
   cpdm_host_model u_host (.*);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [7:0] msk(input logic [7:0] i);
      return i == 8'h07 ? 8'hF3 : i == 8'h08 ? 8'hF0 : i == 8'h09 ? 8'hC7 : i == 8'h0A ? 8'hCF : 8'hFF;
   endfunction
   // field view of a register, boot uses bit 0 only
   function automatic logic [7:0] fld(input logic [7:0] i);
      return i == 8'h07 ? {apd_floppy_q, apd_serial1_q, apd_serial2_q, apd_parallel_q, 3'h0,
         boot_drive_b_q} : i == 8'h0A ? {4'h0, ecp_threshold_q} : i == 8'h0B ? rate_table_sel_q : 8'h00;
   endfunction
   function automatic logic hit_exp(input logic [1:0] md, input logic [10:0] x, input logic sn);
      return md != 2'h0 && !sn && x[10:4] == m && (md == 2'h3 || (md == 2'h2 && !x[3]) || x[3:0] == 4'h0);
   endfunction
   task automatic rd_all(input string n);
      for (int i = 7; i < 12; i++) begin
         u_host.cfg_rd(1'b1, 8'(i), rd, v);
         chk(n, shadow[i], rd);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (8) @(posedge clock);
      #1 rst_n = 1'b1;
      rd_all("reset value");
      // all-ones first, then random writes each read back at once
      for (int k = 0; k < 40; k++) begin
         a = k < 5 ? 8'(7 + k) : 8'h07 + 8'($unsigned($random(seed)) % 5);
         d = k < 5 ? 8'hFF : 8'($random(seed));
         u_host.cfg_wr(1'b1, a, d);
         u_host.cfg_rd(1'b1, a, rd, v);
         shadow[a] = d & msk(a);
         chk("readback", shadow[a], rd);
         chk("valid", 8'h01, {7'h0, v});
         chk("fields", a == 8'h07 ? d & 8'hF1 : a == 8'h0A ? d & 8'h0F : a == 8'h0B ? d : 8'h00,
            fld(a));
      end
      // refused: outside configuration state and just outside the bank
      u_host.cfg_wr(1'b0, 8'h0B, 8'h5A);
      u_host.cfg_rd(1'b0, 8'h0B, rd, v);
      chk("refused", 8'h00, rd | {7'h0, v});
      u_host.cfg_rd(1'b1, 8'h0C, rd, v);
      chk("outside", 8'h00, rd | {7'h0, v});
      rd_all("after refusal");
      // every infrared route; receive pins set so a wrong source reads 0
      for (int r = 0; r < 4; r++) begin
         ir_receive_primary = ~r[0];
         ir_receive_secondary = r[0];
         ir_device_tx = 1'($random(seed)); // transmit source must follow, not stick
         u_host.cfg_wr(1'b1, 8'h0A, {2'(r), 6'h05});
         @(posedge clock);
         #1 chk("ir enables", r == 0 ? 8'h01 : r == 1 ? 8'h02 : r == 2 ? 8'h00 : 8'h03,
            {6'h0, ir_pins_q.tx_primary_oe_n, ir_pins_q.tx_secondary_oe_n});
         chk("ir tx", r == 0 ? {6'h0, ir_device_tx, 1'b0} : r == 1 ? {7'h0, ir_device_tx} : 8'h00,
            {6'h0, ir_pins_q.tx_primary, ir_pins_q.tx_secondary});
         chk("ir rx", {7'h0, r < 2}, {7'h0, ir_pins_q.rx_active});
         shadow[10] = {2'(r), 6'h05};
      end
      // decoder modes against exact, block, near-miss and unselected addresses
      for (int md = 0; md < 4; md++) begin
         m = 7'($random(seed));
         shadow[8] = {m[3:0], 4'h0};
         shadow[9] = {2'(md), 3'h0, m[6:4]};
         u_host.cfg_wr(1'b1, 8'h08, shadow[8]);
         u_host.cfg_wr(1'b1, 8'h09, shadow[9]);
         for (int k = 0; k < 12; k++) begin
            ad = k < 8 ? {m, 4'(k % 4 * 5)} : k == 8 ? {m ^ 7'h01, 4'h0} : 11'($random(seed));
            u_host.addr_drv(ad, k >= 4 && k < 8);
            chk("decode", {7'h0, hit_exp(2'(md), ad, k >= 4 && k < 8)},
               {7'h0, general_addr_decoder_q});
         end
      end
      // hardware reset beats a write in the same cycle
      u_host.cfg_wr(1'b1, 8'h07, 8'hF1);
      hw_reset = 1'b1;
      u_host.cfg_wr(1'b1, 8'h07, 8'hF1);
      hw_reset = 1'b0;
      foreach (shadow[i]) shadow[i] = 8'h00;
      rd_all("hardware reset");
      chk("fields cleared", 8'h00, fld(8'h07) | fld(8'h0A) | fld(8'h0B));
      // power-on reset in mid-run clears a freshly written register again
      u_host.cfg_wr(1'b1, 8'h0B, 8'hA5);
      u_host.cfg_wr(1'b1, 8'h07, 8'hF1);
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      #1 rst_n = 1'b1;
      rd_all("power-on reset");
      chk("fields reset", 8'h00, fld(8'h07) | fld(8'h0B));
      complete_run();
   end
   // hang guard: a run this long counts as a failure
   initial begin
      #400000;
      err_count++;
      complete_run();
   end
endmodule // tb_cpdm_regs
bind cpdm_regs cpdm_regs_properties #(.DRIVES(DRIVES)) u_props (.*);
